/* File: core/dac_cfg_pkg.sv */
package dac_cfg_pkg;

  // Register offsets
  localparam logic [4:0] ADDR_INPUT_FORMAT = 5'h02;
  localparam logic [4:0] ADDR_PROCESSING_MODE = 5'h03;
  localparam logic [4:0] ADDR_TEST_SOURCE = 5'h04;
  localparam logic [4:0] ADDR_STROBE_SYNC = 5'h05;
  localparam logic [4:0] ADDR_FIXED_LOW = 5'h06;
  localparam logic [4:0] ADDR_FIXED_HIGH = 5'h07;
  localparam logic [4:0] ADDR_FACTORY_BYPASS = 5'h08;
  localparam logic [4:0] ADDR_TUNING_BYTE0 = 5'h09;
  localparam logic [4:0] ADDR_TUNING_BYTE1 = 5'h0a;
  localparam logic [4:0] ADDR_TUNING_BYTE2 = 5'h0b;
  localparam logic [4:0] ADDR_TUNING_BYTE3 = 5'h0c;
  localparam logic [4:0] ADDR_ANGLE_BYTE0 = 5'h0d;
  localparam logic [4:0] ADDR_ANGLE_BYTE1 = 5'h0e;
  localparam logic [4:0] ADDR_FIRST = ADDR_INPUT_FORMAT;
  localparam logic [4:0] ADDR_LAST = ADDR_ANGLE_BYTE1;

  // Reset values and writable bits
  localparam logic [7:0] RESET_ZERO = 8'h00;
  localparam logic [7:0] RESET_PROCESSING_MODE = 8'h80;
  localparam logic [7:0] RESET_TUNING_BYTE3 = 8'h40;
  localparam logic [7:0] MASK_ALL = 8'hff;
  localparam logic [7:0] MASK_TEST_SOURCE = 8'hef;
  localparam logic [7:0] MASK_STROBE_SYNC = 8'hfc;

  // input_format_control fields
  localparam int IFC_BMARK = 7;
  localparam int IFC_INTERL = 6;
  localparam int IFC_DUAL_CLK = 5;
  localparam int IFC_SIGNED = 4;
  localparam int IFC_REV_A = 3;
  localparam int IFC_REV_B = 2;
  localparam int IFC_INTERP_BYP = 1;
  localparam int IFC_FULL_BYP = 0;
  // processing_mode_control fields
  localparam int PMC_NCO_EN = 7;
  localparam int PMC_NCO_GAIN = 6;
  localparam int PMC_QMC_EN = 5;
  localparam int PMC_CM_LSB = 0;
  // test_source_control fields
  localparam int TSC_FIXED_SEL = 6;
  localparam int TSC_HALF_RATE = 5;
  localparam int TSC_UPPER_SB = 3;
  localparam int TSC_CNT_LSB = 0;
  // strobe_sync_control fields
  localparam int SSC_DIV = 7;
  localparam int SSC_NCO = 6;
  localparam int SSC_MIX = 5;
  localparam int SSC_FIFO_LSB = 2;

  // FIFO pointer sync sources
  localparam logic [2:0] FSYNC_TXEN = 3'h0;
  localparam logic [2:0] FSYNC_STROBE = 3'h1;
  localparam logic [2:0] FSYNC_FLAG = 3'h2;
  localparam logic [2:0] FSYNC_B15 = 3'h3;
  localparam logic [2:0] FSYNC_A15_ONCE = 3'h4;
  localparam logic [2:0] FSYNC_SOFT = 3'h5;
  localparam logic [2:0] FSYNC_OFF = 3'h6;
  localparam logic [2:0] FSYNC_ALWAYS = 3'h7;

  // Test counter modes
  localparam logic [2:0] CNT_ALL = 3'h4;
  localparam logic [2:0] CNT_LSB7 = 3'h5;
  localparam logic [2:0] CNT_MID5 = 3'h6;
  localparam logic [2:0] CNT_MSB5 = 3'h7;

  // Coarse mixer families, cm bits 3:2
  localparam logic [1:0] CM_HALF = 2'h1;
  localparam logic [1:0] CM_PLUS_QTR = 2'h2;
  localparam logic [1:0] CM_MINUS_QTR = 2'h3;

  localparam logic [15:0] MOST_NEG = 16'h8000;
  localparam logic [15:0] MOST_POS = 16'h7fff;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic pll_disabled;
    logic strobe;
    logic flag;
    logic txen;
    logic [15:0] b;
    logic [15:0] a;
  } pin_bundle_t;

  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
  } sample_pair_t;

  typedef enum logic {SLOT_A, SLOT_B} slot_t;

endpackage

/* File: core/dac_datapath_config.sv */
`timescale 1ns/1ps
// Overview of operation
// [RQ1] Flag pin marks B words, else txen aligns
// [RQ2] Interleaved mode takes A and B from port A
// [RQ3] Two-clock mode only while PLL disabled
// [RQ4] Signed bit picks two's complement or offset binary
// [RQ5] Per-port reverse bit mirrors bus bit order
// [RQ6] Interpolation bypass skips all interpolation filters
// [RQ7] Full bypass skips filters, correction and oscillator
// [RQ8] Oscillator enable resets on; gain bit doubles
// [RQ9] Quadrature correction only while its enable set
// [RQ10] Coarse codes 00XX off, 01XX half-rate
// [RQ11] Codes 10XX plus quarter-rate sequences
// [RQ12] Codes 11XX minus quarter-rate sequences
// [RQ13] Fixed-value select replaces both channel inputs
// [RQ14] Half-rate gathers channel A from both ports
// [RQ15] Upper-sideband bit inverts channel B data
// [RQ16] Counter select replaces output with cyclic counter
// [RQ17] Strobe rising edge restarts enabled sync targets
// [RQ18] Selected source rising edge resets FIFO pointers
// [RQ19] Fixed value low byte first, high second
// [RQ20] Software leaves factory bypass mask at zero
// [RQ21] Tuning word from four bytes, top resets 0x40
// [RQ22] Phase offset low byte holds bits 7:0
// [RQ23] Phase offset upper byte in next register
// [RQ24] Unused bits read zero, others read back
// [RQ25] Reset values, controls reach datapath via registers
module dac_datapath_config
  import dac_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register access
  input wire reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // Sample port pins
  input wire logic [15:0] port_a_data_bus,
  input wire logic [15:0] port_b_data_bus,
  input wire logic transmit_enable_pin,
  input wire logic sample_flag_pin,
  input wire logic phase_strobe_pin,
  input wire logic pll_disabled_pin,
  // Converter data
  output logic [15:0] dac_a_data,
  output logic [15:0] dac_b_data,
  // Stage controls
  output logic dual_clock_mode,
  output logic interp_bypass,
  output logic qmc_active,
  output logic nco_active,
  output logic [15:0] nco_phase,
  output logic divider_restart,
  output logic fifo_ptr_reset
);

  function automatic logic [7:0] reset_value(input logic [4:0] addr);
    if (addr == ADDR_PROCESSING_MODE) begin
      return RESET_PROCESSING_MODE;
    end else if (addr == ADDR_TUNING_BYTE3) begin
      return RESET_TUNING_BYTE3;
    end
    return RESET_ZERO;
  endfunction

  function automatic logic [7:0] write_mask(input logic [4:0] addr);
    if (addr == ADDR_TEST_SOURCE) begin
      return MASK_TEST_SOURCE;
    end else if (addr == ADDR_STROBE_SYNC) begin
      return MASK_STROBE_SYNC;
    end
    return MASK_ALL;
  endfunction

  // Bus order, then number encoding; offset binary becomes signed internally
  function automatic logic [15:0] orient(input logic [15:0] d, input logic rev,
                                         input logic signed_fmt);
    logic [15:0] r;
    r = d;
    if (rev) begin
      for (int i = 0; i < 16; i++) begin
        r[i] = d[15 - i];
      end
    end
    return signed_fmt ? r : {~r[15], r[14:0]};
  endfunction

  // Saturates so the most negative code never wraps to itself
  function automatic logic [15:0] negate(input logic [15:0] x);
    return (x == MOST_NEG) ? MOST_POS : 16'(-x);
  endfunction

  function automatic sample_pair_t coarse_mix(input logic [3:0] code, input logic [1:0] step,
                                              input sample_pair_t s);
    sample_pair_t r;
    r = s;
    unique case (code[3:2])
      CM_HALF: begin
        r.a = (code[1] ^ step[0]) ? s.a : negate(s.a);
        r.b = (code[0] ^ step[0]) ? s.b : negate(s.b);
      end
      CM_PLUS_QTR: begin
        unique case (step)
          2'd0: begin r.a = s.a; r.b = s.b; end
          2'd1: begin r.a = negate(s.b); r.b = s.a; end
          2'd2: begin r.a = negate(s.a); r.b = negate(s.b); end
          2'd3: begin r.a = s.b; r.b = negate(s.a); end
        endcase
      end
      CM_MINUS_QTR: begin
        unique case (step)
          2'd0: begin r.a = s.a; r.b = s.b; end
          2'd1: begin r.a = s.b; r.b = negate(s.a); end
          2'd2: begin r.a = negate(s.a); r.b = negate(s.b); end
          2'd3: begin r.a = negate(s.b); r.b = s.a; end
        endcase
      end
      default: r = s;
    endcase
    if (code[3]) begin
      r.a = code[1] ? negate(r.a) : r.a;
      r.b = code[0] ? negate(r.b) : r.b;
    end
    return r;
  endfunction

  // Register file
  logic [7:0] cfg_q [ADDR_FIRST:ADDR_LAST];
  logic [7:0] sh_q [ADDR_FIRST:ADDR_LAST];
  logic [7:0] reg_rdata_q;
  logic sw_sync_q;

  always_ff @(posedge clk) begin
    for (int i = ADDR_FIRST; i <= ADDR_LAST; i++) begin
      if (!rst_n) begin
        cfg_q[i] <= reset_value(5'(i)); // RQ8 RQ21 RQ25
      end else if (reg_req.wr && reg_req.addr == 5'(i)) begin
        cfg_q[i] <= reg_req.wdata & write_mask(5'(i)); // RQ24
      end
    end
  end

  // One register stage between software and the datapath
  always_ff @(posedge clk) begin
    for (int i = ADDR_FIRST; i <= ADDR_LAST; i++) begin
      if (!rst_n) begin
        sh_q[i] <= reset_value(5'(i));
      end else begin
        sh_q[i] <= cfg_q[i]; // RQ25
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata_q <= RESET_ZERO;
    end else if (reg_req.rd) begin
      if (reg_req.addr >= ADDR_FIRST && reg_req.addr <= ADDR_LAST) begin
        reg_rdata_q <= cfg_q[reg_req.addr]; // RQ24
      end else begin
        reg_rdata_q <= RESET_ZERO;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sw_sync_q <= 1'b0;
    end else begin
      sw_sync_q <= reg_req.wr && reg_req.addr == ADDR_STROBE_SYNC;
    end
  end

  // Control fields as the datapath sees them
  logic bmark_en, interl_en, signed_fmt, rev_a, rev_b, full_byp;
  logic fixed_sel, half_rate, upper_sb;
  logic [3:0] cm_code;
  logic [2:0] cnt_mode, fifo_src;
  logic [15:0] fixed_value, angle_offset;
  logic [31:0] tuning_word;

  assign bmark_en = sh_q[ADDR_INPUT_FORMAT][IFC_BMARK];
  assign interl_en = sh_q[ADDR_INPUT_FORMAT][IFC_INTERL];
  assign signed_fmt = sh_q[ADDR_INPUT_FORMAT][IFC_SIGNED];
  assign rev_a = sh_q[ADDR_INPUT_FORMAT][IFC_REV_A];
  assign rev_b = sh_q[ADDR_INPUT_FORMAT][IFC_REV_B];
  assign full_byp = sh_q[ADDR_INPUT_FORMAT][IFC_FULL_BYP];
  assign fixed_sel = sh_q[ADDR_TEST_SOURCE][TSC_FIXED_SEL];
  assign half_rate = sh_q[ADDR_TEST_SOURCE][TSC_HALF_RATE];
  assign upper_sb = sh_q[ADDR_TEST_SOURCE][TSC_UPPER_SB];
  assign cm_code = sh_q[ADDR_PROCESSING_MODE][PMC_CM_LSB +: 4];
  assign cnt_mode = sh_q[ADDR_TEST_SOURCE][TSC_CNT_LSB +: 3];
  assign fifo_src = sh_q[ADDR_STROBE_SYNC][SSC_FIFO_LSB +: 3];
  assign fixed_value = {sh_q[ADDR_FIXED_HIGH], sh_q[ADDR_FIXED_LOW]}; // RQ19
  assign tuning_word = {sh_q[ADDR_TUNING_BYTE3], sh_q[ADDR_TUNING_BYTE2],
                        sh_q[ADDR_TUNING_BYTE1], sh_q[ADDR_TUNING_BYTE0]}; // RQ21
  assign angle_offset = {sh_q[ADDR_ANGLE_BYTE1], sh_q[ADDR_ANGLE_BYTE0]}; // RQ22 RQ23

  // Pin synchronisers; stage 3 only serves edge detection
  pin_bundle_t pin_s1_q, pin_s2_q, pin_s3_q, pin_now;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
    end else begin
      pin_s1_q <= {pll_disabled_pin, phase_strobe_pin, sample_flag_pin, transmit_enable_pin,
                   port_b_data_bus, port_a_data_bus};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  assign pin_now = pin_s2_q;

  logic txen_rise, strobe_rise, flag_rise, b15_rise, a15_rise;
  assign txen_rise = pin_now.txen && !pin_s3_q.txen;
  assign strobe_rise = pin_now.strobe && !pin_s3_q.strobe;
  assign flag_rise = pin_now.flag && !pin_s3_q.flag;
  assign b15_rise = pin_now.b[15] && !pin_s3_q.b[15];
  assign a15_rise = pin_now.a[15] && !pin_s3_q.a[15];

  // Input assembly
  logic [15:0] fmt_a, fmt_b, held_a_q;
  slot_t slot_q;
  logic is_b_word, half_sel_q;
  sample_pair_t in_q;

  assign fmt_a = orient(pin_now.a, rev_a, signed_fmt); // RQ4 RQ5
  assign fmt_b = orient(pin_now.b, rev_b, signed_fmt); // RQ4 RQ5
  // Without the marker, the word arriving with the txen edge is an A word
  assign is_b_word = bmark_en ? pin_now.flag : (!txen_rise && slot_q == SLOT_B); // RQ1

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      slot_q <= SLOT_A;
    end else if (!interl_en) begin
      slot_q <= SLOT_A;
    end else begin
      slot_q <= is_b_word ? SLOT_A : SLOT_B; // RQ1
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !half_rate || txen_rise) begin
      half_sel_q <= 1'b0;
    end else begin
      half_sel_q <= !half_sel_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      in_q <= '0;
      held_a_q <= '0;
    end else if (fixed_sel) begin
      in_q <= '{a: fixed_value, b: fixed_value}; // RQ13
    end else if (interl_en) begin
      if (is_b_word) begin
        in_q <= '{a: held_a_q, b: fmt_a}; // RQ2
      end else begin
        held_a_q <= fmt_a; // RQ2
      end
    end else if (half_rate) begin
      // Channel B carries no data in this mode
      in_q <= '{a: half_sel_q ? fmt_b : fmt_a, b: 16'h0000}; // RQ14
    end else begin
      in_q <= '{a: fmt_a, b: fmt_b};
    end
  end

  // Oscillator stage
  logic [31:0] nco_acc_q;
  logic [15:0] nco_phase_q;
  logic nco_on, nco_active_q, qmc_active_q, interp_bypass_q, dual_clock_q;
  sample_pair_t proc_q;

  assign nco_on = sh_q[ADDR_PROCESSING_MODE][PMC_NCO_EN] && !full_byp; // RQ7 RQ8

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nco_acc_q <= '0;
    end else if (strobe_rise && sh_q[ADDR_STROBE_SYNC][SSC_NCO]) begin
      nco_acc_q <= '0; // RQ17
    end else if (nco_on) begin
      nco_acc_q <= nco_acc_q + tuning_word; // RQ8
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nco_phase_q <= '0;
    end else begin
      nco_phase_q <= nco_acc_q[31:16] + angle_offset;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      proc_q <= '0;
    end else if (nco_on && sh_q[ADDR_PROCESSING_MODE][PMC_NCO_GAIN]) begin
      // Doubling saturates rather than wraps
      proc_q.a <= (in_q.a[15] != in_q.a[14]) ? (in_q.a[15] ? MOST_NEG : MOST_POS)
                                             : {in_q.a[14:0], 1'b0}; // RQ8
      proc_q.b <= (in_q.b[15] != in_q.b[14]) ? (in_q.b[15] ? MOST_NEG : MOST_POS)
                                             : {in_q.b[14:0], 1'b0}; // RQ8
    end else begin
      proc_q <= in_q; // RQ7
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nco_active_q <= 1'b0;
      qmc_active_q <= 1'b0;
      interp_bypass_q <= 1'b0;
      dual_clock_q <= 1'b0;
    end else begin
      nco_active_q <= nco_on;
      qmc_active_q <= sh_q[ADDR_PROCESSING_MODE][PMC_QMC_EN] && !full_byp; // RQ9 RQ7
      interp_bypass_q <= sh_q[ADDR_INPUT_FORMAT][IFC_INTERP_BYP] || full_byp; // RQ6 RQ7
      dual_clock_q <= sh_q[ADDR_INPUT_FORMAT][IFC_DUAL_CLK] && pin_now.pll_disabled; // RQ3
    end
  end

  // Coarse mixer
  logic [1:0] mix_step_q;
  sample_pair_t mixed;

  always_ff @(posedge clk) begin
    if (!rst_n || (strobe_rise && sh_q[ADDR_STROBE_SYNC][SSC_MIX])) begin
      mix_step_q <= 2'd0; // RQ17
    end else begin
      mix_step_q <= mix_step_q + 2'd1;
    end
  end

  assign mixed = coarse_mix(cm_code, mix_step_q, proc_q); // RQ10 RQ11 RQ12

  // Output selection
  logic [15:0] test_cnt_q, cnt_word, dac_a_q, dac_b_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      test_cnt_q <= '0;
    end else begin
      test_cnt_q <= test_cnt_q + 16'h0001;
    end
  end

  always_comb begin
    cnt_word = test_cnt_q;
    unique case (cnt_mode)
      CNT_LSB7: cnt_word = {9'h000, test_cnt_q[6:0]};
      CNT_MID5: cnt_word = {5'h00, test_cnt_q[4:0], 6'h00};
      CNT_MSB5: cnt_word = {test_cnt_q[4:0], 11'h000};
      default: cnt_word = test_cnt_q;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dac_a_q <= '0;
      dac_b_q <= '0;
    end else if (cnt_mode[2]) begin
      dac_a_q <= cnt_word; // RQ16
      dac_b_q <= cnt_word; // RQ16
    end else begin
      dac_a_q <= mixed.a;
      dac_b_q <= upper_sb ? negate(mixed.b) : mixed.b; // RQ15
    end
  end

  // Sync pulses
  logic divider_restart_q, fifo_ptr_reset_q, a15_armed_q, fifo_event;

  always_comb begin
    unique case (fifo_src)
      FSYNC_TXEN: fifo_event = txen_rise;
      FSYNC_STROBE: fifo_event = strobe_rise;
      FSYNC_FLAG: fifo_event = flag_rise;
      FSYNC_B15: fifo_event = b15_rise;
      FSYNC_A15_ONCE: fifo_event = a15_rise && a15_armed_q;
      FSYNC_SOFT: fifo_event = sw_sync_q;
      FSYNC_OFF: fifo_event = 1'b0;
      FSYNC_ALWAYS: fifo_event = 1'b1;
    endcase
  end

  // Rearming on every sync register write lets software retry the one-shot
  always_ff @(posedge clk) begin
    if (!rst_n || sw_sync_q) begin
      a15_armed_q <= 1'b1;
    end else if (fifo_src == FSYNC_A15_ONCE && a15_rise) begin
      a15_armed_q <= 1'b0; // RQ18
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      divider_restart_q <= 1'b0;
      fifo_ptr_reset_q <= 1'b0;
    end else begin
      divider_restart_q <= strobe_rise && sh_q[ADDR_STROBE_SYNC][SSC_DIV]; // RQ17
      fifo_ptr_reset_q <= fifo_event; // RQ18
    end
  end

  assign reg_rdata = reg_rdata_q;
  assign dac_a_data = dac_a_q;
  assign dac_b_data = dac_b_q;
  assign dual_clock_mode = dual_clock_q;
  assign interp_bypass = interp_bypass_q;
  assign qmc_active = qmc_active_q;
  assign nco_active = nco_active_q;
  assign nco_phase = nco_phase_q;
  assign divider_restart = divider_restart_q;
  assign fifo_ptr_reset = fifo_ptr_reset_q;

endmodule

/* File: bench/dac_datapath_config_checker.sv */
`timescale 1ns/1ps
module dac_datapath_config_checker
  import dac_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register access
  input wire reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  // Pins
  input wire logic phase_strobe_pin,
  input wire logic pll_disabled_pin,
  // Stage controls
  input wire logic dual_clock_mode,
  input wire logic interp_bypass,
  input wire logic qmc_active,
  input wire logic nco_active,
  input wire logic divider_restart
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic wr_cfg;
  logic wr_mode;
  assign wr_cfg = reg_req.wr && reg_req.addr == ADDR_INPUT_FORMAT;
  assign wr_mode = reg_req.wr && reg_req.addr == ADDR_PROCESSING_MODE;

  chk_unmapped_read_zero: assert property (
    reg_req.rd && (reg_req.addr < ADDR_FIRST || reg_req.addr > ADDR_LAST) |=> reg_rdata == 8'h00)
    else $error("Unmapped read returned nonzero data");
  chk_rdata_holds: assert property (
    !reg_req.rd |=> $stable(reg_rdata))
    else $error("Read data changed without a read");
  chk_test_unused_zero: assert property (
    reg_req.rd && reg_req.addr == ADDR_TEST_SOURCE |=> !reg_rdata[4])
    else $error("Unused test source bit reads one");
  chk_sync_unused_zero: assert property (
    reg_req.rd && reg_req.addr == ADDR_STROBE_SYNC |=> reg_rdata[1:0] == 2'b00)
    else $error("Unused sync bits read nonzero");
  chk_full_bypass_all: assert property (
    wr_cfg && reg_req.wdata[IFC_FULL_BYP] |-> ##3 interp_bypass && !qmc_active && !nco_active)
    else $error("Full bypass left a stage active");
  chk_interp_bypass_set: assert property (
    wr_cfg && reg_req.wdata[IFC_INTERP_BYP] |-> ##3 interp_bypass)
    else $error("Interpolation bypass not applied");
  chk_nco_disable: assert property (
    wr_mode && !reg_req.wdata[PMC_NCO_EN] |-> ##3 !nco_active)
    else $error("Oscillator active while disabled");
  chk_qmc_disable: assert property (
    wr_mode && !reg_req.wdata[PMC_QMC_EN] |-> ##3 !qmc_active)
    else $error("Correction active while disabled");
  chk_dual_clk_gate: assert property (
    !pll_disabled_pin [*4] |-> !dual_clock_mode)
    else $error("Two-clock mode while PLL enabled");
  chk_restart_needs_strobe: assert property (
    !phase_strobe_pin [*8] |-> !divider_restart)
    else $error("Divider restart without strobe edge");
  chk_restart_one_cycle: assert property (
    divider_restart |=> !divider_restart)
    else $error("Divider restart longer than one cycle");
endmodule

bind dac_datapath_config dac_datapath_config_checker u_dac_datapath_config_checker (
  .clk(clk),
  .rst_n(rst_n),
  .reg_req(reg_req),
  .reg_rdata(reg_rdata),
  .phase_strobe_pin(phase_strobe_pin),
  .pll_disabled_pin(pll_disabled_pin),
  .dual_clock_mode(dual_clock_mode),
  .interp_bypass(interp_bypass),
  .qmc_active(qmc_active),
  .nco_active(nco_active),
  .divider_restart(divider_restart)
);

/* File: bench/sample_source_model.sv */
`timescale 1ns/1ps
module sample_source_model
  import dac_cfg_pkg::*;
(
  // Stimulus control
  input wire logic clk,
  input wire logic [1:0] mode,
  input wire sample_pair_t words,
  // Sample pins
  output logic [15:0] port_a,
  output logic [15:0] port_b,
  output logic txen,
  output logic flag
);
  logic b_slot = 1'b0;
  initial begin
    port_a = 16'h0000;
    port_b = 16'h0000;
    txen = 1'b0;
    flag = 1'b0;
  end
  // Unused buses keep toggling so a stale value never looks valid
  always @(negedge clk) begin
    // Held in the B phase while idle so the word with the txen edge is an A word
    b_slot <= mode == 2'd0 ? 1'b1 : ~b_slot;
    txen <= mode != 2'd0;
    flag <= mode == 2'd1 && !b_slot;
    port_a <= mode == 2'd0 ? ~port_a : (mode == 2'd1 && !b_slot) ? words.b : words.a;
    port_b <= mode == 2'd2 ? words.b : ~port_b;
  end
endmodule

/* File: bench/dac_datapath_config_tb.sv */
`timescale 1ns/1ps
module dac_datapath_config_tb;
  import dac_cfg_pkg::*;
  logic clk;
  logic rst_n;
  reg_req_t reg_req;
  logic [7:0] reg_rdata;
  logic [15:0] port_a, port_b, dac_a, dac_b, nco_phase, a0, b0, n0, mask;
  logic txen, flag, strobe, pll_dis, dual_clk, interp_byp, qmc_act, nco_act, div_rst, fifo_rst;
  logic [1:0] mode;
  sample_pair_t words;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int nd, nf;
  // Address, write data, expected read back
  localparam logic [23:0] ROWS [16] = '{24'h02_a7a7, 24'h03_5a5a, 24'h04_ffef, 24'h05_fffc,
    24'h06_3434, 24'h07_1212, 24'h08_0000, 24'h09_1111, 24'h0a_2222, 24'h0b_3333,
    24'h0c_4444, 24'h0d_5555, 24'h0e_6666, 24'h1f_7700, 24'h00_8800, 24'h10_9900};

  dac_datapath_config u_dac_datapath_config (
    .clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .port_a_data_bus(port_a), .port_b_data_bus(port_b), .transmit_enable_pin(txen),
    .sample_flag_pin(flag), .phase_strobe_pin(strobe), .pll_disabled_pin(pll_dis),
    .dac_a_data(dac_a), .dac_b_data(dac_b), .dual_clock_mode(dual_clk),
    .interp_bypass(interp_byp), .qmc_active(qmc_act), .nco_active(nco_act),
    .nco_phase(nco_phase), .divider_restart(div_rst), .fifo_ptr_reset(fifo_rst)
  );
  sample_source_model u_sample_source_model (
    .clk(clk), .mode(mode), .words(words), .port_a(port_a), .port_b(port_b),
    .txen(txen), .flag(flag)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a[4:0], wdata: d};
    @(negedge clk);
    reg_req = '0;
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a[4:0], wdata: 8'h00};
    @(negedge clk);
    reg_req = '0;
    @(negedge clk);
    check({8'h00, reg_rdata}, {8'h00, exp});
  endtask

  task automatic do_reset();
    @(negedge clk);
    rst_n = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    for (int a = 0; a < 32; a++)
      rd_check(a[7:0], a == 3 ? 8'h80 : a == 12 ? 8'h40 : 8'h00);
  endtask

  function automatic logic [15:0] rev16(input logic [15:0] v);
    for (int i = 0; i < 16; i++)
      rev16[i] = v[15 - i];
  endfunction

  initial begin
    rst_n = 1'b0;
    reg_req = '0;
    strobe = 1'b0;
    pll_dis = 1'b0;
    mode = 2'd0;
    words = '{a: 16'h9a31, b: 16'h4c07};
    do_reset();
    for (int i = 0; i < 16; i++) begin
      wr(ROWS[i][23:16], ROWS[i][15:8]);
      rd_check(ROWS[i][23:16], ROWS[i][7:0]);
    end
    // Second reset after every register except factory bypass (written with zero) was disturbed
    do_reset();
    n0 = nco_phase;
    idle(1);
    check(nco_phase - n0, 16'h4000);
    wr(8'h02, 8'h20);
    pll_dis = 1'b1;
    idle(6);
    check({15'h0000, dual_clk}, 16'h0001);
    pll_dis = 1'b0;
    idle(6);
    check({15'h0000, dual_clk}, 16'h0000);
    wr(8'h06, 8'h34);
    wr(8'h07, 8'h12);
    wr(8'h04, 8'h40);
    idle(8);
    check(dac_a, 16'h1234);
    check(dac_b, 16'h1234);
    for (int cm = 0; cm < 16; cm++) begin
      wr(8'h03, cm[7:0]);
      idle(8);
      a0 = dac_a;
      b0 = dac_b;
      idle(cm > 7 ? 2 : 1);
      check(dac_a, cm < 4 ? a0 : -a0);
      check(dac_b, cm < 4 ? b0 : -b0);
      check({15'h0000, a0 == 16'h1234 || a0 == 16'hedcc}, 16'h0001);
    end
    wr(8'h03, 8'h00);
    wr(8'h04, 8'h48);
    idle(8);
    check(dac_a, 16'h1234);
    check(dac_b, 16'hedcc);
    for (int m = 4; m < 8; m++) begin
      wr(8'h04, m[7:0]);
      idle(8);
      a0 = dac_a;
      check(dac_b, a0);
      idle(1);
      mask = m == 4 ? 16'hffff : m == 5 ? 16'h007f : m == 6 ? 16'h07c0 : 16'hf800;
      check(a0 & ~mask, 16'h0000);
      check(dac_a, (a0 + (m == 6 ? 16'h0040 : m == 7 ? 16'h0800 : 16'h0001)) & mask);
    end
    wr(8'h04, 8'h00);
    mode = 2'd1;
    for (int k = 0; k < 3; k++) begin
      wr(8'h02, k == 0 ? 8'hd0 : k == 1 ? 8'hc0 : 8'hd8);
      idle(12);
      check(dac_a, k == 1 ? words.a ^ MOST_NEG : k == 2 ? rev16(words.a) : words.a);
      check(dac_b, k == 1 ? words.b ^ MOST_NEG : k == 2 ? rev16(words.b) : words.b);
    end
    // No marker: the txen rising edge alone fixes which word is A
    mode = 2'd0;
    wr(8'h02, 8'h50);
    idle(4);
    mode = 2'd1;
    idle(12);
    check(dac_a, words.a);
    check(dac_b, words.b);
    mode = 2'd2;
    wr(8'h02, 8'h14);
    wr(8'h04, 8'h20);
    idle(12);
    a0 = dac_a;
    idle(1);
    check(dac_b, 16'h0000);
    check(a0 ^ dac_a, words.a ^ rev16(words.b));
    check({15'h0000, a0 == words.a || a0 == rev16(words.b)}, 16'h0001);
    mode = 2'd0;
    wr(8'h04, 8'h00);
    for (int s = 0; s < 8; s++) begin
      wr(8'h05, 8'he0 | (s[7:0] << 2));
      idle(5);
      reg_req = '{wr: 1'b0, rd: 1'b0, addr: ADDR_STROBE_SYNC, wdata: 8'he0 | (s[7:0] << 2)};
      idle(1);
      nd = 0;
      nf = 0;
      for (int c = 0; c < 16; c++) begin
        strobe = c > 0 && c < 5;
        // Repeat write fires the software source and rearms the one-shot
        reg_req.wr = c == 8 && (s == 4 || s == 5);
        @(negedge clk);
        nd += div_rst;
        nf += fifo_rst;
      end
      check(nd[15:0], 16'h0001);
      check(nf[15:0], (s == 1 || s == 4 || s == 5) ? 16'h0001 : s == 3 ? 16'h0008 :
            s == 7 ? 16'h0010 : 16'h0000);
    end
    close_out();
  end
endmodule
